/* inc/sector_map_regs.svh */
// Offsets, field values, factory defaults and bus answers of the parameter block.
// Assumes a 12-bit AXI4-Lite byte address; every register is one aligned word.
`ifndef SECTOR_MAP_REGS_SVH
`define SECTOR_MAP_REGS_SVH

// ==========================================================
// Register byte offsets
`define OFS_HYBRID_SMALL 12'h07c
`define OFS_UNIFORM_HEADER 12'h080
`define OFS_UNIFORM_REGION 12'h084
`define OFS_STATUS_ONE 12'h100
`define OFS_CONFIG_ONE 12'h104
`define OFS_CONFIG_TWO 12'h108
`define OFS_CONFIG_THREE 12'h10c
`define OFS_CONFIG_FOUR 12'h110
`define OFS_PASSWORD_LO 12'h114
`define OFS_PASSWORD_HI 12'h118
`define OFS_SCHEME 12'h11c
`define OFS_VIEW_SEL 12'h120
`define OFS_VIEW_DATA 12'h124
`define OFS_LOCK_CLEAR 12'h128

// ==========================================================
// Sector-map descriptor fields
`define RESERVED_NIBBLE 4'hf
`define ERASE_4K 4'b0001
`define ERASE_256K 4'b0100
`define HYBRID_SMALL_UNITS 24'h00007f
`define UNIFORM_UNITS 24'h03ffff
`define HDR_RESERVED 8'hff
`define HDR_REGION_COUNT 8'h00
`define HDR_CONFIG_ID 8'h05
`define HDR_LOW_RESERVED 6'h3f
`define HDR_MAP_DESC 1'b1
`define HDR_END_DESC 1'b1
`define TABLE_BYTES 12

// ==========================================================
// View selector layout
`define VIEW_INDEX_MSB 9
`define VIEW_SPACE_LSB 10
`define VIEW_SPACE_MSB 11

// ==========================================================
// Factory defaults
`define ERASED_BYTE 8'hff
`define OTP_SEED_BYTES 16
`define OTP_BYTES 1024
`define SECTOR_COUNT 256
`define STATUS_ONE_RESET 8'h00
`define CONFIG_ONE_RESET 8'h00
`define CONFIG_TWO_RESET 8'h08
`define CONFIG_THREE_RESET 8'h00
`define CONFIG_FOUR_RESET 8'h10
`define PASSWORD_RESET 48'hffff_ffff_ffff
`define SCHEME_RESET 16'hffff
`define LOCK_RESET 1'b1

// ==========================================================
// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

`endif

/* inc/sector_map_pkg.sv */
// Types and descriptor builders shared by the parameter block files.
// Assumes the constants header is on the include path.
`include "sector_map_regs.svh"

package sector_map_pkg;

  typedef logic [1:0] resp_t;

  typedef enum logic [1:0]
  {
    space_table = 2'b00,
    space_array = 2'b01,
    space_otp = 2'b10,
    space_lock = 2'b11
  } space_t;

  // Erase-type byte: reserved nibble high, support flags low
  function automatic logic [7:0] erase_byte(input logic [3:0] types);
    erase_byte = {`RESERVED_NIBBLE, types};
  endfunction

  function automatic logic [31:0] region_dword(input logic [23:0] units, input logic [3:0] types);
    region_dword = {units, erase_byte(types)};
  endfunction

  function automatic logic [31:0] header_dword();
    header_dword = {`HDR_RESERVED, `HDR_REGION_COUNT, `HDR_CONFIG_ID, `HDR_LOW_RESERVED, `HDR_MAP_DESC,
                    `HDR_END_DESC};
  endfunction

endpackage

/* core/param_byte_view.sv */
// Byte-wide view into the parameter table, main array, one-time area and lock bits.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns

module param_byte_view
  import sector_map_pkg::*;
#(
  // Factory random number; value arbitrary
  parameter logic [127:0] OTP_SEED = 128'h5a3c_96e1_0f7b_d248_a6c3_1e95_7d02_b4f8
)
(
  // Selection
  input wire space_t view_space,
  input wire logic [9:0] view_index,
  // Lock state
  input wire logic [255:0] lock_bits,
  // Result
  output logic [7:0] view_byte
);

  logic [95:0] table_words;

  assign table_words = {region_dword(`UNIFORM_UNITS, `ERASE_256K), header_dword(),
                        region_dword(`HYBRID_SMALL_UNITS, `ERASE_4K)};

  always_comb
  begin
    view_byte = `ERASED_BYTE;
    unique case (view_space)
      space_table:
      begin
        // Least significant byte first at ascending offsets
        if (view_index < 10'(`TABLE_BYTES))
          view_byte = table_words[8*view_index[3:0] +: 8];
      end
      space_array:
        view_byte = `ERASED_BYTE;
      space_otp:
      begin
        if (view_index < 10'(`OTP_SEED_BYTES))
          view_byte = OTP_SEED[8*view_index[3:0] +: 8];
        else
          view_byte = `ERASED_BYTE;
      end
      space_lock:
      begin
        if (view_index < 10'(`SECTOR_COUNT))
          view_byte = {7'h00, lock_bits[view_index[7:0]]};
        else
          view_byte = 8'h00;
      end
    endcase
  end

endmodule

/* core/sector_map_table.sv */
// AXI4-Lite slave holding the sector-map descriptors and the factory default state.
// Assumes one clock, a synchronous active-high reset and a well-behaved master.
// How it works
// - Hybrid small-sector descriptor advertises only the 4-KB erase type.
// - Erase flags read 1 supported, 0 not; reserved upper nibble reads ones.
// - Uniform header: bits 31:24 ones, region count zero, configuration id five.
// - Uniform header low byte: reserved ones, map descriptor bit, end bit.
// - Uniform region size field holds 03ffffh, 256-byte units minus one.
// - Uniform region descriptor advertises only the 256-KB erase type.
// - Main array reads erased, every byte ffh.
// - One-time area: first 16 bytes random, the rest ffh.
// - Persistent first status register starts at 00h.
// - Persistent configuration registers one to four start 00h, 08h, 00h, 10h.
// - Password register starts all ones.
// - All per-sector lock bits start set; protection scheme starts ffffh.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns

module sector_map_table
  import sector_map_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  // Write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  // Read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ==========================================================
  // Persistent state
  // Writes program, except to the view selector: bits only go from 1 to 0, as in the cell array.
  // Nothing else here erases, so a cleared bit stays cleared until reset.
  logic [7:0] status_one;
  logic [7:0] config_reg [4];
  logic [47:0] password;
  logic [15:0] scheme;
  logic [255:0] lock_bits;
  logic [11:0] view_sel;
  logic [7:0] next_status_one;
  logic [7:0] next_config_reg [4];
  logic [47:0] next_password;
  logic [15:0] next_scheme;
  logic [255:0] next_lock_bits;
  logic [11:0] next_view_sel;

  // ==========================================================
  // Bus state
  logic aw_held;
  logic [11:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic [11:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  resp_t next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  resp_t next_rresp;
  logic do_write;
  logic [7:0] view_byte;
  logic [31:0] rd_word;
  resp_t rd_resp;

  function automatic logic [31:0] program32(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] keep;
    keep = {{8{~strb[3]}}, {8{~strb[2]}}, {8{~strb[1]}}, {8{~strb[0]}}};
    program32 = old & (data | keep);
  endfunction

  function automatic resp_t write_resp(input logic [11:0] addr);
    unique case (addr)
      `OFS_STATUS_ONE, `OFS_CONFIG_ONE, `OFS_CONFIG_TWO, `OFS_CONFIG_THREE, `OFS_CONFIG_FOUR,
      `OFS_PASSWORD_LO, `OFS_PASSWORD_HI, `OFS_SCHEME, `OFS_VIEW_SEL, `OFS_LOCK_CLEAR:
        write_resp = `RESP_OKAY;
      `OFS_HYBRID_SMALL, `OFS_UNIFORM_HEADER, `OFS_UNIFORM_REGION, `OFS_VIEW_DATA:
        write_resp = `RESP_SLVERR;
      default:
        write_resp = `RESP_DECERR;
    endcase
  endfunction

  param_byte_view param_byte_view_inst
  (
    .view_space(space_t'(view_sel[`VIEW_SPACE_MSB:`VIEW_SPACE_LSB])),
    .view_index(view_sel[`VIEW_INDEX_MSB:0]),
    .lock_bits(lock_bits),
    .view_byte(view_byte)
  );

  // ==========================================================
  // Write channel
  // Address and data are taken in either order; the response waits for both.
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = {awaddr[11:2], 2'b00};
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = write_resp(aw_addr);
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
  end

  always_comb
  begin
    next_status_one = status_one;
    next_config_reg = config_reg;
    next_password = password;
    next_scheme = scheme;
    next_lock_bits = lock_bits;
    next_view_sel = view_sel;
    if (do_write)
    begin
      unique case (aw_addr)
        `OFS_STATUS_ONE:
          next_status_one = 8'(program32({24'h0, status_one}, w_data, w_strb));
        `OFS_CONFIG_ONE:
          next_config_reg[0] = 8'(program32({24'h0, config_reg[0]}, w_data, w_strb));
        `OFS_CONFIG_TWO:
          next_config_reg[1] = 8'(program32({24'h0, config_reg[1]}, w_data, w_strb));
        `OFS_CONFIG_THREE:
          next_config_reg[2] = 8'(program32({24'h0, config_reg[2]}, w_data, w_strb));
        `OFS_CONFIG_FOUR:
          next_config_reg[3] = 8'(program32({24'h0, config_reg[3]}, w_data, w_strb));
        `OFS_PASSWORD_LO:
          next_password[31:0] = program32(password[31:0], w_data, w_strb);
        `OFS_PASSWORD_HI:
          next_password[47:32] = 16'(program32({16'h0, password[47:32]}, w_data, w_strb));
        `OFS_SCHEME:
          next_scheme = 16'(program32({16'h0, scheme}, w_data, w_strb));
        `OFS_VIEW_SEL:
        begin
          if (w_strb[0])
            next_view_sel[7:0] = w_data[7:0];
          if (w_strb[1])
            next_view_sel[11:8] = w_data[11:8];
        end
        `OFS_LOCK_CLEAR:
        begin
          if (w_strb[0])
            next_lock_bits[w_data[7:0]] = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // Read channel
  // One cycle from address to data; the view byte is taken at that edge.
  assign arready = !rvalid;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_resp = `RESP_OKAY;
    unique case ({araddr[11:2], 2'b00})
      `OFS_HYBRID_SMALL:
        rd_word = region_dword(`HYBRID_SMALL_UNITS, `ERASE_4K);
      `OFS_UNIFORM_HEADER:
        rd_word = header_dword();
      `OFS_UNIFORM_REGION:
        rd_word = region_dword(`UNIFORM_UNITS, `ERASE_256K);
      `OFS_STATUS_ONE:
        rd_word = {24'h0, status_one};
      `OFS_CONFIG_ONE:
        rd_word = {24'h0, config_reg[0]};
      `OFS_CONFIG_TWO:
        rd_word = {24'h0, config_reg[1]};
      `OFS_CONFIG_THREE:
        rd_word = {24'h0, config_reg[2]};
      `OFS_CONFIG_FOUR:
        rd_word = {24'h0, config_reg[3]};
      `OFS_PASSWORD_LO:
        rd_word = password[31:0];
      `OFS_PASSWORD_HI:
        rd_word = {16'h0, password[47:32]};
      `OFS_SCHEME:
        rd_word = {16'h0, scheme};
      `OFS_VIEW_SEL:
        rd_word = {20'h0, view_sel};
      `OFS_VIEW_DATA:
        rd_word = {24'h0, view_byte};
      `OFS_LOCK_CLEAR:
        rd_word = 32'h0000_0000;
      default:
        rd_resp = `RESP_DECERR;
    endcase
  end

  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_resp;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_one <= `STATUS_ONE_RESET;
      config_reg[0] <= `CONFIG_ONE_RESET;
      config_reg[1] <= `CONFIG_TWO_RESET;
      config_reg[2] <= `CONFIG_THREE_RESET;
      config_reg[3] <= `CONFIG_FOUR_RESET;
      password <= `PASSWORD_RESET;
      scheme <= `SCHEME_RESET;
      lock_bits <= {`SECTOR_COUNT{`LOCK_RESET}};
      view_sel <= 12'h000;
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else
    begin
      status_one <= next_status_one;
      config_reg <= next_config_reg;
      password <= next_password;
      scheme <= next_scheme;
      lock_bits <= next_lock_bits;
      view_sel <= next_view_sel;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ==========================================================
  // Checks
  sequence read_of(logic [11:0] a);
    arvalid && arready && araddr == a;
  endsequence

  sequence view_read(logic [1:0] s);
    arvalid && arready && araddr == `OFS_VIEW_DATA && view_sel[11:10] == s && view_sel[9:0] >= 10'd16;
  endsequence

  chk_hybrid_erase_byte: assert property (@(posedge clk) disable iff (reset)
    read_of(`OFS_HYBRID_SMALL) |=> rdata[3:0] == 4'b0001 && rresp == `RESP_OKAY)
    else $error("hybrid small region erase flags wrong");

  chk_reserved_nibble: assert property (@(posedge clk) disable iff (reset)
    (arvalid && arready && (araddr == `OFS_HYBRID_SMALL || araddr == `OFS_UNIFORM_REGION)) |=> rdata[7:4] == 4'hf)
    else $error("reserved nibble not ones");

  chk_header_upper: assert property (@(posedge clk) disable iff (reset)
    read_of(`OFS_UNIFORM_HEADER) |=> rdata[31:8] == 24'hff0005)
    else $error("uniform header upper bytes wrong");

  chk_header_low: assert property (@(posedge clk) disable iff (reset)
    read_of(`OFS_UNIFORM_HEADER) |=> rdata[7:0] == 8'hff)
    else $error("uniform header low byte wrong");

  chk_region_size: assert property (@(posedge clk) disable iff (reset)
    read_of(`OFS_UNIFORM_REGION) |=> rdata[31:8] == 24'h03ffff && rvalid)
    else $error("uniform region size wrong");

  chk_region_erase: assert property (@(posedge clk) disable iff (reset)
    read_of(`OFS_UNIFORM_REGION) |=> rdata[3:0] == 4'b0100)
    else $error("uniform region erase flags wrong");

  chk_array_erased: assert property (@(posedge clk) disable iff (reset)
    view_read(2'b01) |=> rdata == 32'h0000_00ff)
    else $error("main array not erased");

  chk_otp_tail: assert property (@(posedge clk) disable iff (reset)
    view_read(2'b10) |=> rdata == 32'h0000_00ff)
    else $error("one-time area tail not erased");

  chk_status_default: assert property (@(posedge clk)
    $past(reset) |-> status_one == 8'h00)
    else $error("status default wrong");

  chk_config_default: assert property (@(posedge clk)
    $past(reset) |-> config_reg[1] == 8'h08 && config_reg[3] == 8'h10 && config_reg[0] == 8'h00)
    else $error("configuration default wrong");

  chk_password_default: assert property (@(posedge clk)
    $past(reset) |-> password == 48'hffff_ffff_ffff)
    else $error("password default wrong");

  chk_lock_default: assert property (@(posedge clk)
    $past(reset) |-> scheme == 16'hffff && &lock_bits)
    else $error("protection default wrong");

  chk_byte_order: assert property (@(posedge clk) disable iff (reset)
    (arvalid && arready && araddr == `OFS_VIEW_DATA && view_sel == 12'h004) |=> rdata[7:0] == 8'hff)
    else $error("table byte order wrong");

  chk_write_answer: assert property (@(posedge clk) disable iff (reset)
    (do_write || (bvalid && !bready)) |=> bvalid)
    else $error("write response missing");

endmodule

/* sim/lite_host.sv */
// ==========================================================
// Register-bus host model: one AXI4-Lite read or write at a time.
// Assumes its tasks are called by the bench's single main process.
`timescale 1ns/1ns

module lite_host
(
  // Clock
  input wire logic clk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [11:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [11:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end

  // Each task opens a cycle later so no strobe is driven twice in one step
  task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r, output bit hung);
    hung = 1'b1;
    r = 2'bxx;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        hung = 1'b0;
        break;
      end
    end
  endtask

  task automatic read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
                      output bit hung);
    hung = 1'b1;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        hung = 1'b0;
        break;
      end
    end
  endtask
endmodule

/* sim/sector_map_table_tb.sv */
// ==========================================================
// Self-checking bench for the sector-map parameter block.
// Assumes the host model owns the register bus; the bench owns clock and reset.
`timescale 1ns/1ns
`include "sector_map_regs.svh"

module sector_map_table_tb;
  import sector_map_pkg::*;
  logic clk, reset;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int errors;
  int n_compared;

  sector_map_table sector_map_table_inst (.clk(clk), .reset(reset),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));

  lite_host lite_host_inst (.clk(clk),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang_check(input bit hung);
    if (hung)
    begin
      errors++;
      $display("mismatch bus_answer expected response seen none");
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit hung;
    lite_host_inst.read(a, d, r, hung);
    hang_check(hung);
    check($sformatf("rdata_%h", a), d, exp);
    check($sformatf("rresp_%h", a), {30'h0, r}, {30'h0, er});
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    bit hung;
    lite_host_inst.write(a, d, s, r, hung);
    hang_check(hung);
    check($sformatf("bresp_%h", a), {30'h0, r}, {30'h0, er});
  endtask

  task automatic view(input space_t sp, input int idx, input logic [7:0] exp);
    wr_chk(`OFS_VIEW_SEL, {20'h0, sp, 10'(idx)}, 4'hf, 2'b00);
    rd_chk(`OFS_VIEW_DATA, {24'h0, exp}, 2'b00);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    rd_chk(`OFS_HYBRID_SMALL, {24'h00007f, 4'hf, 4'b0001}, 2'b00);
    rd_chk(`OFS_UNIFORM_HEADER, {8'hff, 8'h00, 8'h05, 6'b111111, 1'b1, 1'b1}, 2'b00);
    rd_chk(`OFS_UNIFORM_REGION, {24'h03ffff, 4'hf, 4'b0100}, 2'b00);
    rd_chk(`OFS_STATUS_ONE, 32'h00, 2'b00);
    rd_chk(`OFS_CONFIG_ONE, 32'h00, 2'b00);
    rd_chk(`OFS_CONFIG_TWO, 32'h08, 2'b00);
    rd_chk(`OFS_CONFIG_THREE, 32'h00, 2'b00);
    rd_chk(`OFS_CONFIG_FOUR, 32'h10, 2'b00);
    rd_chk(`OFS_PASSWORD_LO, 32'hffffffff, 2'b00);
    rd_chk(`OFS_PASSWORD_HI, 32'h0000ffff, 2'b00);
    rd_chk(`OFS_SCHEME, 32'h0000ffff, 2'b00);
    $display("test defaults done, mismatches %0d", errors);
  endtask

  // Table words must survive writes and unmapped places must answer as errors
  task automatic t_read_only();
    wr_chk(`OFS_UNIFORM_HEADER, 32'h0, 4'hf, 2'b10);
    rd_chk(`OFS_UNIFORM_HEADER, 32'hff0005ff, 2'b00);
    wr_chk(`OFS_UNIFORM_REGION, 32'h0, 4'hf, 2'b10);
    rd_chk(`OFS_UNIFORM_REGION, 32'h03fffff4, 2'b00);
    rd_chk(12'h200, 32'h0, 2'b11);
    wr_chk(12'h200, 32'h0, 4'hf, 2'b11);
    $display("test read_only done, mismatches %0d", errors);
  endtask

  task automatic t_table_bytes();
    logic [31:0] dw [3];
    dw = '{32'h00007ff1, 32'hff0005ff, 32'h03fffff4};
    for (int i = 0; i < 12; i++)
      view(space_table, i, dw[i / 4][8 * (i % 4) +: 8]);
    $display("test table_bytes done, mismatches %0d", errors);
  endtask

  task automatic t_array_otp();
    int idx [4];
    idx = '{0, 1, 511, 1023};
    for (int i = 0; i < 4; i++)
      view(space_array, idx[i], 8'hff);
    view(space_otp, 16, 8'hff);
    view(space_otp, 17, 8'hff);
    view(space_otp, 1023, 8'hff);
    $display("test array_otp done, mismatches %0d", errors);
  endtask

  // A cleared lock must come back set after reset, and neighbours stay set
  task automatic t_locks();
    view(space_lock, 0, 8'h01);
    view(space_lock, 255, 8'h01);
    wr_chk(`OFS_LOCK_CLEAR, 32'h05, 4'h1, 2'b00);
    view(space_lock, 5, 8'h00);
    view(space_lock, 4, 8'h01);
    view(space_lock, 6, 8'h01);
    wr_chk(`OFS_CONFIG_TWO, 32'h0, 4'hf, 2'b00);
    rd_chk(`OFS_CONFIG_TWO, 32'h00, 2'b00);
    do_reset();
    view(space_lock, 5, 8'h01);
    rd_chk(`OFS_CONFIG_TWO, 32'h08, 2'b00);
    $display("test locks done, mismatches %0d", errors);
  endtask

  initial
  begin
    errors = 0;
    n_compared = 0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_read_only();
    t_table_bytes();
    t_array_otp();
    t_locks();
    test_done();
  end
endmodule
